// [pkg/slp_pkg.sv]
package slp_pkg;
  // Clock and time figures
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned MIN_ON_MS = 100;
  localparam int unsigned TRIP_HOLD_S = 3;
  localparam int unsigned DELAY_STEP_MS = 100;
  localparam int unsigned MIN_ON_CYC = (CLK_HZ / 1000) * MIN_ON_MS;
  localparam int unsigned TRIP_CYC = CLK_HZ * TRIP_HOLD_S;
  localparam int unsigned STEP_CYC = (CLK_HZ / 1000) * DELAY_STEP_MS;

  // Setting units: percent in 0.1 %, frequency in 0.01 Hz, delay in 0.1 s
  localparam logic [15:0] PCT_MAX = 16'h07d0;
  localparam logic [15:0] NOT_SET = 16'h270f;
  localparam logic [15:0] FACTOR_UNITY = 16'h03e8;
  localparam logic [15:0] FREQ_MAX = 16'h9c40;
  localparam logic [15:0] DECEL_FLOOR = 16'h01f4;
  localparam logic [15:0] HOLD_FREQ = 16'h0064;
  localparam logic [15:0] DELAY_MAX = 16'h00fa;
  localparam logic [15:0] FUNC_MAX = 16'h001f;
  localparam logic [15:0] FUNC_ALT0 = 16'h0064;
  localparam logic [15:0] FUNC_ALT1 = 16'h0065;
  localparam logic [15:0] TERM_POS = 16'h0003;
  localparam logic [15:0] TERM_NEG = 16'h0067;
  localparam logic [15:0] WP_RUN_OK = 16'h0002;

  // Reset values
  localparam logic [15:0] LEVEL_RST = 16'h05dc;
  localparam logic [15:0] REDUCE_RST = 16'h1388;
  localparam logic [15:0] FAST_RST = 16'h0834;
  localparam logic [15:0] MAXF_RST = 16'h2ee0;

  // Word addresses
  localparam logic [3:0] A_LEVEL = 4'h0;
  localparam logic [3:0] A_FACTOR = 4'h1;
  localparam logic [3:0] A_SECOND = 4'h2;
  localparam logic [3:0] A_RFREQ = 4'h3;
  localparam logic [3:0] A_FSEL = 4'h4;
  localparam logic [3:0] A_DELAY = 4'h5;
  localparam logic [3:0] A_LQTY = 4'h6;
  localparam logic [3:0] A_UGRP = 4'h7;
  localparam logic [3:0] A_WPROT = 4'h8;
  localparam logic [3:0] A_TERM = 4'h9;
  localparam logic [3:0] A_FAST = 4'ha;
  localparam logic [3:0] A_STATUS = 4'hb;
  localparam logic [3:0] A_MAXF = 4'hc;

  // Function select bits, status bits
  localparam int unsigned FS_NO_FAST = 0;
  localparam int unsigned FS_NO_ACC = 1;
  localparam int unsigned FS_NO_CONST = 2;
  localparam int unsigned FS_NO_DEC = 3;
  localparam int unsigned FS_TRIP = 4;
  localparam int unsigned ST_TRIP = 0;
  localparam int unsigned ST_STALL = 1;
  localparam int unsigned ST_IND = 2;
  localparam int unsigned ST_SHUT = 3;
endpackage

// [src/slp_run_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module slp_run_timer #(
  parameter int unsigned LIMIT_CYCLES = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic en,
  output logic done
);
  typedef struct packed {
    logic [31:0] cnt;
    logic done;
  } slp_run_st_t;

  slp_run_st_t st_reg;
  slp_run_st_t st_next;

  // Counts only while enabled; any gap restarts the count
  always_comb begin
    st_next = st_reg;
    if (!en) begin
      st_next.cnt = '0;
      st_next.done = 1'b0;
    end else if (st_reg.cnt >= LIMIT_CYCLES - 1) begin
      st_next.done = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign done = st_reg.done;
endmodule
`default_nettype wire

// [src/slp_delay_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module slp_delay_timer
  import slp_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = STEP_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cond,
  input wire logic [15:0] delay_set,
  output logic out
);
  typedef struct packed {
    logic [31:0] pre;
    logic [15:0] steps;
    logic out;
  } slp_dly_st_t;

  slp_dly_st_t st_reg;
  slp_dly_st_t st_next;

  // Step prescaler and step count run only while the condition holds
  always_comb begin
    st_next = st_reg;
    if (!cond || delay_set == NOT_SET) begin
      st_next = '0;
    end else if (st_reg.steps >= delay_set) begin
      st_next.out = 1'b1;
    end else if (st_reg.pre >= STEP_CYCLES - 1) begin
      st_next.pre = '0;
      st_next.steps = st_reg.steps + 16'h0001;
    end else begin
      st_next.pre = st_reg.pre + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out = st_reg.out;
endmodule
`default_nettype wire

// [src/slp_limiter.sv]
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
//Contract
//- Current above level drives frequency back down
//- Fast limiter shuts output above limit
//- Stall level 0.1-200 %, 150 % default, 0 off
//- Factor lowers level above start; 9999 fixed
//- Second level; 0 off, 9999 equals primary
//- Reduction start frequency 0-400 Hz, 50 Hz
//- Select codes 0-31, 100, 101 gate functions
//- Hold accel, decel at constant, hold decel
//- Indicator asserted while stall prevention acts
//- Switch picks output or torque current
//- Regenerative torque limit raises frequency to maximum
//- Torque limit off at 5 Hz decelerating
//- Indicator holds over 100 ms, clears below
//- Regeneration avoidance or bus stall also indicate
//- Delay 0 immediate, 0.1-25 s, 9999 none
//- Terminal code 3 high, 103 low
//- Stall level writable while running always
//- Settings reachable only with user group zero; user group, write protect, terminal, fast limit and maximum frequency registers are not gated
//- Held at 1 Hz for 3 s trips
//- Second function input selects second level
module slp_limiter
  import slp_pkg::*;
#(
  parameter int unsigned MIN_ON_CYCLES = MIN_ON_CYC,
  parameter int unsigned TRIP_CYCLES = TRIP_CYC,
  parameter int unsigned STEP_CYCLES = STEP_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  // Register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Stage feedback and drive state
  input wire logic [15:0] out_current,
  input wire logic [15:0] torque_current,
  input wire logic [15:0] out_freq,
  input wire logic accel_active,
  input wire logic decel_active,
  input wire logic regen_active,
  input wire logic drive_running,
  input wire logic regen_avoid_active,
  input wire logic dc_bus_stall,
  input wire logic second_function_select,
  // Commands and indication
  output logic ramp_hold,
  output logic ramp_decel,
  output logic ramp_raise,
  output logic output_shutoff,
  output logic stall_active,
  output logic stall_indicator,
  output logic stall_indicator_term,
  output logic sustained_stall_trip
);
  import slp_pkg::*;

  typedef struct packed {
    // Host settings
    logic [15:0] stall_level_setting;
    logic [15:0] high_speed_level_factor;
    logic [15:0] second_stall_level;
    logic [15:0] reduction_start_frequency;
    logic [15:0] stall_function_select;
    logic [15:0] indication_delay;
    logic [15:0] limit_quantity_switch;
    logic [15:0] user_group_read_select;
    logic [15:0] write_protect_select;
    logic [15:0] output_terminal_function;
    logic [15:0] fast_limit_level;
    logic [15:0] max_frequency;

    // Handshake and live status
    logic ack;
    logic [15:0] rdata;
    logic [31:0] hold_cnt;
    logic ind;
    logic shut;
    logic trip;
    logic stall;
    logic hold;
    logic decel;
    logic raise;
    logic term;
  } slp_st_t;

  slp_st_t st_reg;
  slp_st_t st_next;

  logic [15:0] cmp_val;
  logic [15:0] base_lvl;
  logic [31:0] prod;
  logic [15:0] red_lvl;
  logic [15:0] act_lvl;

  logic phase_ok;
  logic torque_low;
  logic over;
  logic stall_now;
  logic ind_cond;
  logic delayed;
  logic trip_done;

  logic wr_go;
  logic rd_go;
  logic grp_ok;
  logic run_lock;
  logic [15:0] wd;
  logic pct_ok;
  logic pct9_ok;

  // Compared quantity and active level
  always_comb begin
    cmp_val = st_reg.limit_quantity_switch[0] ? torque_current : out_current;

    if (second_function_select && st_reg.second_stall_level != NOT_SET) begin
      base_lvl = st_reg.second_stall_level;
    end else begin
      base_lvl = st_reg.stall_level_setting;
    end

    prod = base_lvl * st_reg.high_speed_level_factor;
    red_lvl = 16'(prod / 32'(FACTOR_UNITY));
    act_lvl = base_lvl;

    // Step stand-in for the reduction curve; only ever lowers the level
    if (st_reg.high_speed_level_factor != NOT_SET
        && out_freq > st_reg.reduction_start_frequency
        && red_lvl < base_lvl) begin
      act_lvl = red_lvl;
    end
  end

  // Which ramp phases may be limited, and the stall decision
  always_comb begin
    phase_ok = 1'b0;
    if (accel_active) begin
      phase_ok = !st_reg.stall_function_select[FS_NO_ACC];
    end else if (decel_active) begin
      phase_ok = !st_reg.stall_function_select[FS_NO_DEC];
    end else begin
      phase_ok = !st_reg.stall_function_select[FS_NO_CONST];
    end

    torque_low = st_reg.limit_quantity_switch[0] && decel_active
                 && out_freq <= DECEL_FLOOR;
    over = act_lvl != 16'h0000 && cmp_val > act_lvl;
    stall_now = over && phase_ok && !torque_low && drive_running;

    // Trip-select codes remove the indicator for all three sources; only a stall trips instead
    ind_cond = (stall_now || regen_avoid_active || dc_bus_stall)
               && !st_reg.stall_function_select[FS_TRIP];
  end

  // Indicator start delay
  slp_delay_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_delay (
    .clk(clk),
    .sys_rst(sys_rst),
    .cond(ind_cond),
    .delay_set(st_reg.indication_delay),
    .out(delayed)
  );

  // Sustained stall near standstill
  slp_run_timer #(
    .LIMIT_CYCLES(TRIP_CYCLES)
  ) u_trip (
    .clk(clk),
    .sys_rst(sys_rst),
    .en(stall_now && out_freq <= HOLD_FREQ),
    .done(trip_done)
  );

  // Write value checks and access gates
  always_comb begin
    wd = avs_writedata[15:0];
    pct_ok = avs_writedata[31:16] == 16'h0000 && wd <= PCT_MAX;
    pct9_ok = pct_ok || (avs_writedata[31:16] == 16'h0000 && wd == NOT_SET);

    grp_ok = st_reg.user_group_read_select == 16'h0000;
    run_lock = drive_running && st_reg.write_protect_select != WP_RUN_OK;

    wr_go = avs_write && st_reg.ack;
    rd_go = avs_read && !st_reg.ack;
  end

  // Register updates, control outputs and indicator
  always_comb begin
    st_next = st_reg;
    st_next.ack = (avs_read || avs_write) && !st_reg.ack;

    // Read data captured in the first cycle, presented in the second
    if (rd_go) begin
      st_next.rdata = 16'h0000;
      unique case (avs_address)
        A_LEVEL: st_next.rdata = grp_ok ? st_reg.stall_level_setting : 16'h0000;
        A_FACTOR: st_next.rdata = grp_ok ? st_reg.high_speed_level_factor : 16'h0000;
        A_SECOND: st_next.rdata = grp_ok ? st_reg.second_stall_level : 16'h0000;
        A_RFREQ: st_next.rdata = grp_ok ? st_reg.reduction_start_frequency : 16'h0000;
        A_FSEL: st_next.rdata = grp_ok ? st_reg.stall_function_select : 16'h0000;
        A_DELAY: st_next.rdata = grp_ok ? st_reg.indication_delay : 16'h0000;
        A_LQTY: st_next.rdata = grp_ok ? st_reg.limit_quantity_switch : 16'h0000;

        // Outside the user group gate
        A_UGRP: st_next.rdata = st_reg.user_group_read_select;
        A_WPROT: st_next.rdata = st_reg.write_protect_select;
        A_TERM: st_next.rdata = st_reg.output_terminal_function;
        A_FAST: st_next.rdata = st_reg.fast_limit_level;
        A_MAXF: st_next.rdata = st_reg.max_frequency;
        A_STATUS: begin
          st_next.rdata[ST_TRIP] = st_reg.trip;
          st_next.rdata[ST_STALL] = st_reg.stall;
          st_next.rdata[ST_IND] = st_reg.ind;
          st_next.rdata[ST_SHUT] = st_reg.shut;
        end
        default: st_next.rdata = 16'h0000;
      endcase
    end

    // Illegal values are dropped; the stall level ignores the run lock
    if (wr_go) begin
      unique case (avs_address)
        A_LEVEL: begin
          if (grp_ok && pct_ok) begin
            st_next.stall_level_setting = wd;
          end
        end
        A_FACTOR: if (grp_ok && !run_lock && pct9_ok) st_next.high_speed_level_factor = wd;
        A_SECOND: if (grp_ok && !run_lock && pct9_ok) st_next.second_stall_level = wd;
        A_RFREQ: begin
          if (grp_ok && !run_lock && avs_writedata[31:16] == 16'h0000 && wd <= FREQ_MAX) begin
            st_next.reduction_start_frequency = wd;
          end
        end

        A_FSEL: begin
          if (grp_ok && !run_lock && avs_writedata[31:16] == 16'h0000
              && (wd <= FUNC_MAX || wd == FUNC_ALT0 || wd == FUNC_ALT1)) begin
            st_next.stall_function_select = wd;
          end
        end

        A_DELAY: begin
          if (grp_ok && !run_lock && avs_writedata[31:16] == 16'h0000
              && (wd <= DELAY_MAX || wd == NOT_SET)) begin
            st_next.indication_delay = wd;
          end
        end

        A_LQTY: begin
          if (grp_ok && !run_lock && avs_writedata[31:1] == 31'h0) begin
            st_next.limit_quantity_switch = wd;
          end
        end

        A_UGRP: st_next.user_group_read_select = wd;
        A_WPROT: st_next.write_protect_select = wd;

        // Not group gated; all but the status clear still locked while running
        A_TERM: if (!run_lock) st_next.output_terminal_function = wd;
        A_FAST: if (!run_lock) st_next.fast_limit_level = wd;
        A_MAXF: if (!run_lock) st_next.max_frequency = wd;
        A_STATUS: if (avs_writedata[ST_TRIP]) st_next.trip = 1'b0;
        default: begin end
      endcase
    end

    // Ramp commands for the frequency generator
    st_next.stall = stall_now;
    st_next.hold = stall_now && (accel_active || decel_active);
    st_next.decel = stall_now && !accel_active && !decel_active;
    st_next.raise = stall_now && st_reg.limit_quantity_switch[0] && regen_active
                    && out_freq < st_reg.max_frequency;

    // Fast-response limit always looks at the real output current
    st_next.shut = !st_reg.stall_function_select[FS_NO_FAST]
                   && out_current > st_reg.fast_limit_level;

    // Trip is sticky; a new event beats a software clear
    if (trip_done || (st_reg.stall_function_select[FS_TRIP] && stall_now)) begin
      st_next.trip = 1'b1;
    end

    // Minimum on time once asserted, then follow the condition
    if (delayed) begin
      st_next.ind = 1'b1;
      if (!st_reg.ind) begin
        st_next.hold_cnt = 32'(MIN_ON_CYCLES);
      end else if (st_reg.hold_cnt != 32'h0000_0000) begin
        st_next.hold_cnt = st_reg.hold_cnt - 32'h0000_0001;
      end
    end else if (st_reg.ind && st_reg.hold_cnt != 32'h0000_0000) begin
      st_next.hold_cnt = st_reg.hold_cnt - 32'h0000_0001;
    end else begin
      st_next.ind = 1'b0;
    end

    // Terminal mapping and polarity
    if (st_reg.output_terminal_function == TERM_POS) begin
      st_next.term = st_next.ind;
    end else if (st_reg.output_terminal_function == TERM_NEG) begin
      st_next.term = !st_next.ind;
    end else begin
      st_next.term = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.stall_level_setting <= LEVEL_RST;
      st_reg.high_speed_level_factor <= NOT_SET;
      st_reg.second_stall_level <= NOT_SET;
      st_reg.reduction_start_frequency <= REDUCE_RST;
      st_reg.output_terminal_function <= TERM_POS;
      st_reg.fast_limit_level <= FAST_RST;
      st_reg.max_frequency <= MAXF_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Slave answers in the second cycle of every access
  assign avs_waitrequest = (avs_read || avs_write) && !st_reg.ack;
  assign avs_readdata = {16'h0000, st_reg.rdata};

  assign ramp_hold = st_reg.hold;
  assign ramp_decel = st_reg.decel;
  assign ramp_raise = st_reg.raise;
  assign output_shutoff = st_reg.shut || st_reg.trip;
  assign stall_active = st_reg.stall;
  assign stall_indicator = st_reg.ind;
  assign stall_indicator_term = st_reg.term;
  assign sustained_stall_trip = st_reg.trip;
endmodule
`default_nettype wire

// [testbench/slp_limiter_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module slp_limiter_properties #(
  parameter int unsigned MIN_ON_CYCLES = slp_pkg::MIN_ON_CYC,
  parameter int unsigned TRIP_CYCLES = slp_pkg::TRIP_CYC,
  parameter int unsigned STEP_CYCLES = slp_pkg::STEP_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic accel_active,
  input wire logic decel_active,
  input wire logic regen_active,
  input wire logic drive_running,
  input wire logic ramp_hold,
  input wire logic ramp_decel,
  input wire logic ramp_raise,
  input wire logic output_shutoff,
  input wire logic stall_active,
  input wire logic stall_indicator,
  input wire logic sustained_stall_trip
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Every access answers after exactly one wait cycle
  bus_wait_a: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("Bus wait cycle wrong");
  // A stopped drive never stalls
  no_run_a: assert property (!drive_running |=> !stall_active)
    else $error("Stall while stopped");
  // Ramp action must match the ramp phase that caused it
  hold_cause_a: assert property (
    ramp_hold |-> stall_active && $past(accel_active || decel_active))
    else $error("Ramp hold without stall in a ramp");
  decel_cause_a: assert property (
    ramp_decel |-> stall_active && !$past(accel_active || decel_active))
    else $error("Decel without stall at constant speed");
  raise_cause_a: assert property (
    ramp_raise |-> stall_active && $past(regen_active))
    else $error("Raise without regenerative stall");
  // A trip keeps the stage off and only a status write clears it
  trip_shut_a: assert property (sustained_stall_trip |-> ##[0:1] output_shutoff)
    else $error("Trip without shutoff");
  trip_sticky_a: assert property (
    sustained_stall_trip && !avs_write |=> sustained_stall_trip)
    else $error("Trip dropped by itself");
  // Minimum on-time: a short unrolled check, then the full span by counter
  min_on_a: assert property ($rose(stall_indicator) |-> stall_indicator[*8])
    else $error("Indicator pulse too short");
  int unsigned on_cnt;
  always_ff @(posedge clk) begin
    on_cnt <= (sys_rst || !stall_indicator) ? 32'h0 : on_cnt + 32'h1;
  end
  min_span_a: assert property ($fell(stall_indicator) |-> on_cnt > MIN_ON_CYCLES)
    else $error("Indicator shorter than minimum");
  ind_c: cover property ($rose(stall_indicator));
  trip_c: cover property ($rose(sustained_stall_trip));
  raise_c: cover property (ramp_raise);
endmodule
bind slp_limiter slp_limiter_properties #(
  .MIN_ON_CYCLES(MIN_ON_CYCLES), .TRIP_CYCLES(TRIP_CYCLES), .STEP_CYCLES(STEP_CYCLES)
) chk_u (
  .clk, .sys_rst, .avs_read, .avs_write, .avs_waitrequest, .accel_active, .decel_active,
  .regen_active, .drive_running, .ramp_hold, .ramp_decel, .ramp_raise, .output_shutoff,
  .stall_active, .stall_indicator, .sustained_stall_trip
);
`default_nettype wire

// [testbench/slp_motor_model.sv]
`timescale 1ns/1ps
`default_nettype none
module slp_motor_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] load_cmd,
  input wire logic [15:0] torq_cmd,
  input wire logic [15:0] freq_cmd,
  input wire logic ramp_hold,
  input wire logic ramp_decel,
  input wire logic ramp_raise,
  input wire logic output_shutoff,
  output logic [15:0] out_current,
  output logic [15:0] torque_current,
  output logic [15:0] out_freq
);
  typedef struct packed {
    logic [15:0] freq;
  } slp_motor_state_t;
  slp_motor_state_t st_reg;
  slp_motor_state_t st_next;
  // Limiter commands win over the speed command
  always_comb begin
    st_next = st_reg;
    if (ramp_decel) begin
      st_next.freq = (st_reg.freq > 16'h000a) ? st_reg.freq - 16'h000a : 16'h0000;
    end else if (ramp_raise) begin
      st_next.freq = st_reg.freq + 16'h000a;
    end else if (!ramp_hold) begin
      st_next.freq = freq_cmd;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  // A cut-off stage carries no current, so the limiter sees zero
  assign out_current = output_shutoff ? 16'h0000 : load_cmd;
  assign torque_current = output_shutoff ? 16'h0000 : torq_cmd;
  assign out_freq = st_reg.freq;
endmodule
`default_nettype wire

// [testbench/slp_limiter_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module slp_limiter_tb;
  import slp_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [31:0] wd = 32'h0;
  logic run = 1'b0;
  logic acc = 1'b0;
  logic dec = 1'b0;
  logic rgn = 1'b0;
  logic rav = 1'b0;
  logic dcb = 1'b0;
  logic sfs = 1'b0;
  logic [15:0] load = 16'h0;
  logic [15:0] torq = 16'h0;
  logic [15:0] fcmd = 16'h0fa0;
  logic [31:0] d;
  logic [7:0] s;
  int fail_count = 0;
  int n_compared = 0;
  wire logic [31:0] rdata;
  wire logic wreq;
  wire logic [15:0] cur, tcur, frq;
  wire logic hold, dcl, rse, shut, stl, ind, term, trip;
  wire logic [7:0] outs = {trip, term, ind, stl, shut, rse, dcl, hold};
  // Short counts keep the run brief
  slp_limiter #(.MIN_ON_CYCLES(20), .TRIP_CYCLES(50), .STEP_CYCLES(10)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
    .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wreq), .out_current(cur),
    .torque_current(tcur), .out_freq(frq), .accel_active(acc), .decel_active(dec),
    .regen_active(rgn), .drive_running(run), .regen_avoid_active(rav), .dc_bus_stall(dcb),
    .second_function_select(sfs), .ramp_hold(hold), .ramp_decel(dcl), .ramp_raise(rse),
    .output_shutoff(shut), .stall_active(stl), .stall_indicator(ind),
    .stall_indicator_term(term), .sustained_stall_trip(trip));
  slp_motor_model motor_u (
    .clk(clk), .sys_rst(sys_rst), .load_cmd(load), .torq_cmd(torq), .freq_cmd(fcmd),
    .ramp_hold(hold), .ramp_decel(dcl), .ramp_raise(rse), .output_shutoff(shut),
    .out_current(cur), .torque_current(tcur), .out_freq(frq));
  always #2 clk = ~clk;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One access; everything held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    adr <= a;
    wd <= {16'h0, v};
    wr_s <= w;
    rd_s <= !w;
    @(posedge clk);
    while (wreq) @(posedge clk);
    d = rdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask
  // Collects every output that went high in the next n cycles
  task automatic watch(input int n);
    s = 8'h0;
    repeat (n) begin
      @(posedge clk);
      #1;
      s = s | outs;
    end
  endtask
  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic t_regs;
    logic [3:0] ra [11] = '{A_LEVEL, A_FACTOR, A_SECOND, A_RFREQ, A_FSEL, A_DELAY, A_LQTY,
                           A_TERM, A_FAST, A_MAXF, 4'hd};
    logic [15:0] rv [11] = '{LEVEL_RST, NOT_SET, NOT_SET, REDUCE_RST, 16'h0, 16'h0, 16'h0,
                            TERM_POS, FAST_RST, MAXF_RST, 16'h0};
    logic [15:0] v;
    for (int i = 0; i < 11; i++) begin
      bus(1'b0, ra[i], 16'h0);
      chk("reset value", d, {16'h0, rv[i]});
    end
    // Codes 0..31, 100, 101, then 102 which must be ignored
    for (int c = 0; c < 35; c++) begin
      v = (c < 32) ? 16'(c) : 16'(c + 68);
      bus(1'b1, A_FSEL, v);
      bus(1'b0, A_FSEL, 16'h0);
      chk("select code", d, {16'h0, (c == 34) ? FUNC_ALT1 : v});
    end
    bus(1'b1, A_FSEL, 16'h0);
    bus(1'b1, A_LEVEL, 16'h07d1);
    bus(1'b0, A_LEVEL, 16'h0);
    chk("level out of range", d, {16'h0, LEVEL_RST});
    bus(1'b1, A_UGRP, 16'h0001);
    bus(1'b0, A_LEVEL, 16'h0);
    chk("group gated read", d, 32'h0);
    bus(1'b1, A_UGRP, 16'h0);
  endtask
  task automatic t_stall;
    @(posedge clk);
    run <= 1'b1;
    acc <= 1'b1;
    load <= 16'h0640;
    watch(3);
    chk("hold on accel", s[0], 1'b1);
    @(posedge clk);
    acc <= 1'b0;
    watch(4);
    chk("decel at constant speed", s[1], 1'b1);
    chk("frequency pulled down", frq < 16'h0fa0, 1'b1);
    chk("indicator on", ind, 1'b1);
    bus(1'b1, A_LEVEL, 16'h0708);
    bus(1'b1, A_DELAY, 16'h0005);
    bus(1'b0, A_LEVEL, 16'h0);
    chk("level written running", d, 32'h0708);
    bus(1'b0, A_DELAY, 16'h0);
    chk("delay locked running", d, 32'h0);
    watch(30);
    chk("indicator released", ind, 1'b0);
    bus(1'b1, A_LEVEL, 16'h0);
    watch(6);
    chk("zero level disables", s[4], 1'b0);
    @(posedge clk);
    run <= 1'b0;
    load <= 16'h0;
    bus(1'b1, A_LEVEL, LEVEL_RST);
  endtask
  task automatic t_second;
    bus(1'b1, A_SECOND, 16'h0708);
    @(posedge clk);
    sfs <= 1'b1;
    run <= 1'b1;
    load <= 16'h0640;
    watch(6);
    chk("second level in force", s[4], 1'b0);
    @(posedge clk);
    sfs <= 1'b0;
    watch(4);
    chk("primary level back", stl, 1'b1);
    @(posedge clk);
    run <= 1'b0;
    load <= 16'h0;
    bus(1'b1, A_SECOND, NOT_SET);
  endtask
  task automatic t_delay;
    watch(30);
    bus(1'b1, A_DELAY, 16'h0001);
    @(posedge clk);
    run <= 1'b1;
    load <= 16'h0640;
    watch(6);
    @(posedge clk);
    load <= 16'h0;
    watch(2);
    @(posedge clk);
    load <= 16'h0640;
    watch(8);
    chk("delay restarts", s[5], 1'b0);
    watch(8);
    chk("delayed indicator", ind, 1'b1);
    @(posedge clk);
    run <= 1'b0;
    load <= 16'h0;
    watch(30);
    bus(1'b1, A_DELAY, NOT_SET);
    @(posedge clk);
    run <= 1'b1;
    load <= 16'h0640;
    watch(30);
    chk("indicator suppressed", s[5], 1'b0);
    @(posedge clk);
    run <= 1'b0;
    load <= 16'h0;
    bus(1'b1, A_DELAY, 16'h0);
  endtask
  task automatic t_src;
    bus(1'b1, A_TERM, TERM_NEG);
    @(posedge clk);
    run <= 1'b1;
    rav <= 1'b1;
    watch(4);
    chk("regen avoid indicates", ind, 1'b1);
    chk("low active terminal", term, 1'b0);
    @(posedge clk);
    rav <= 1'b0;
    watch(30);
    chk("terminal idle level", term, 1'b1);
    @(posedge clk);
    dcb <= 1'b1;
    watch(4);
    chk("bus stall indicates", ind, 1'b1);
    @(posedge clk);
    dcb <= 1'b0;
    run <= 1'b0;
    watch(30);
    bus(1'b1, A_TERM, 16'h0005);
    watch(2);
    chk("unassigned terminal", term, 1'b0);
    bus(1'b1, A_TERM, TERM_POS);
  endtask
  task automatic t_torque;
    bus(1'b1, A_LQTY, 16'h0001);
    @(posedge clk);
    run <= 1'b1;
    load <= 16'h076c;
    torq <= 16'h03e8;
    fcmd <= 16'h01f4;
    watch(6);
    chk("torque is compared", s[4], 1'b0);
    @(posedge clk);
    dec <= 1'b1;
    rgn <= 1'b1;
    torq <= 16'h0640;
    watch(6);
    chk("no limit at 5 Hz", s[4], 1'b0);
    @(posedge clk);
    fcmd <= 16'h0bb8;
    watch(8);
    chk("regen limit raises", s[2], 1'b1);
    chk("frequency raised", frq > 16'h0bb8, 1'b1);
    @(posedge clk);
    run <= 1'b0;
    dec <= 1'b0;
    rgn <= 1'b0;
    torq <= 16'h0;
    load <= 16'h0;
    fcmd <= 16'h0fa0;
    bus(1'b1, A_LQTY, 16'h0);
  endtask
  task automatic t_fast;
    @(posedge clk);
    run <= 1'b1;
    load <= 16'h0898;
    watch(3);
    chk("fast limit cuts output", s[3], 1'b1);
    @(posedge clk);
    run <= 1'b0;
    bus(1'b1, A_FSEL, 16'h0001);
    @(posedge clk);
    run <= 1'b1;
    watch(6);
    chk("fast limit deselected", s[3], 1'b0);
    @(posedge clk);
    run <= 1'b0;
    load <= 16'h0640;
    fcmd <= 16'h0064;
    bus(1'b1, A_FSEL, 16'h0);
    @(posedge clk);
    run <= 1'b1;
    watch(70);
    chk("sustained stall trips", s[7], 1'b1);
    chk("trip holds output off", shut, 1'b1);
    @(posedge clk);
    run <= 1'b0;
    load <= 16'h0;
    bus(1'b1, A_STATUS, 16'h0001);
    bus(1'b0, A_STATUS, 16'h0);
    chk("trip cleared", d[0], 1'b0);
  endtask
  // Whole run is under a thousand cycles; twenty thousand means a hang
  initial begin
    #80000;
    fail_count++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_stall();
    t_second();
    t_delay();
    t_src();
    t_torque();
    t_fast();
    close_out();
  end
endmodule
`default_nettype wire
